// ### hw/wdr_pkg.sv
// Constants for the watchdog and reset-cause block: offsets, fields, resets, counts.
// Assumes an 8-bit core register port with data-space and I/O-space addressing.

package wdr_pkg;

  // Register map, data-space offsets
  localparam logic [7:0] ADDR_CAUSE = 8'h54;
  localparam logic [7:0] ADDR_CTRL = 8'h60;
  localparam logic [7:0] IO_OFFSET = 8'h20;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Control register fields
  localparam int CTRL_IF = 7;
  localparam int CTRL_IE = 6;
  localparam int CTRL_PS3 = 5;
  localparam int CTRL_CE = 4;
  localparam int CTRL_RE = 3;
  localparam int CTRL_PS_HI = 2;

  // Cause register fields
  localparam int CAUSE_WD = 3;
  localparam int CAUSE_BO = 2;
  localparam int CAUSE_EXT = 1;
  localparam int CAUSE_PO = 0;

  // Timing
  localparam int OSC_FREQ_KHZ = 128;
  localparam int TOUT_MIN_MS = 16;
  localparam int TOUT_MAX_MS = 8000;
  localparam logic [2:0] CE_CYCLES = 3'h4;
  localparam logic [3:0] PSEL_MAX = 4'h9;
  localparam int CNT_W = 20;
  localparam logic [20:0] BASE_CYC = 21'h000800;

endpackage : wdr_pkg

// ### hw/wdr_osc_tick.sv
// Turns the free-running low-frequency oscillator into one-cycle ticks on clk_sys.
// Assumes the oscillator is far slower than clk_sys so no edge is missed.
`timescale 1ns/10ps
`default_nettype none

module wdr_osc_tick (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Oscillator from its own domain
  input wire logic osc_in,
  // One pulse per oscillator cycle
  output logic tick
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic tick_d;

  // Rising edge of the synchronised oscillator
  assign tick_d = sync2_q & ~prev_q;

  // Two-stage synchroniser, the first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      tick <= 1'b0;
    end else begin
      sync1_q <= osc_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      tick <= tick_d;
    end
  end

endmodule : wdr_osc_tick

`default_nettype wire

// ### hw/wdr_top.sv
// Watchdog timer with timed change protection and the reset-cause flag register.
// Assumes the core drives the register port and strobes on clk_sys, and that
// rst_n is the power-on reset of this block only, not the watchdog's own reset.
`timescale 1ns/10ps
`default_nettype none

module wdr_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Low-frequency oscillator, asynchronous to clk_sys
  input wire logic osc_in,
  // Register port from the core
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic io_space,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Core events
  input wire logic restart,
  input wire logic vector_taken,
  input wire logic global_int_enable,
  // Fuse, programmed when high
  input wire logic always_on_fuse,
  // Reset events from the reset detectors, one-cycle pulses
  input wire logic poweron_evt,
  input wire logic brownout_evt,
  input wire logic external_evt,
  // Outputs to the system
  output logic wdt_reset_pulse,
  output logic startup_delay_start,
  output logic wdt_irq
);

  logic tick;
  logic [7:0] addr_eff;
  logic wr_ctrl;
  logic wr_cause;
  logic rd_ctrl;
  logic rd_cause;
  logic open_wr;
  logic chg_wr;
  logic ce_open;
  logic re_eff;
  logic ie_eff;
  logic run;
  logic expire;
  logic rst_fire;
  logic set_flag;
  logic clr_flag;
  logic vec_clr_ie;
  logic [19:0] cnt_last;
  logic [7:0] ctrl_view;
  logic [7:0] cause_view;
  logic [7:0] rdata_d;
  logic [2:0] ce_cnt_q;
  logic [2:0] ce_cnt_d;
  logic re_q;
  logic re_d;
  logic ie_q;
  logic ie_d;
  logic flag_q;
  logic flag_d;
  logic [3:0] psel_q;
  logic [3:0] psel_d;
  logic [19:0] cnt_q;
  logic [19:0] cnt_d;
  logic [3:0] cause_q;
  logic [3:0] cause_d;
  logic irq_d;

  // Last count before expiry; reserved codes run at the longest period
  function automatic logic [19:0] last_count(input logic [3:0] psel);
    logic [3:0] p;
    logic [20:0] full;
    p = (psel > wdr_pkg::PSEL_MAX) ? wdr_pkg::PSEL_MAX : psel;
    full = wdr_pkg::BASE_CYC << p;
    return 20'(full - 21'h000001);
  endfunction : last_count

  wdr_osc_tick u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .osc_in(osc_in),
    .tick(tick)
  );

  // Address decode: I/O addresses sit 0x20 below the data-space offsets
  assign addr_eff = io_space ? (reg_addr + wdr_pkg::IO_OFFSET) : reg_addr;
  assign wr_ctrl = reg_wr && (addr_eff == wdr_pkg::ADDR_CTRL);
  assign wr_cause = reg_wr && (addr_eff == wdr_pkg::ADDR_CAUSE);
  assign rd_ctrl = addr_eff == wdr_pkg::ADDR_CTRL;
  assign rd_cause = addr_eff == wdr_pkg::ADDR_CAUSE;

  // Effective mode bits; the fuse and a pending watchdog cause override software
  assign re_eff = re_q | cause_q[wdr_pkg::CAUSE_WD] | always_on_fuse;
  assign ie_eff = ie_q & ~always_on_fuse;
  assign run = re_eff | ie_eff;

  // Timed change sequence
  assign ce_open = ce_cnt_q != 3'h0;
  assign open_wr = wr_ctrl && reg_wdata[wdr_pkg::CTRL_CE] && reg_wdata[wdr_pkg::CTRL_RE];
  assign chg_wr = wr_ctrl && ce_open && !reg_wdata[wdr_pkg::CTRL_CE];

  // Expiry and the action it takes
  assign cnt_last = last_count(psel_q);
  assign expire = tick && run && (cnt_q == cnt_last);
  // A pending flag at expiry in combined mode means the vector never ran
  assign rst_fire = expire && re_eff && (!ie_eff || flag_q);
  assign set_flag = expire && ie_eff && !rst_fire;
  assign clr_flag = vector_taken || (wr_ctrl && reg_wdata[wdr_pkg::CTRL_IF]);
  assign vec_clr_ie = vector_taken && re_eff;

  // Register read views
  assign ctrl_view = {flag_q, ie_eff, psel_q[3], ce_open, re_eff, psel_q[2:0]};
  assign cause_view = {4'h0, cause_q};
  assign rdata_d = rd_ctrl ? ctrl_view : (rd_cause ? cause_view : 8'h00);
  assign irq_d = global_int_enable && ie_eff && flag_q;

  // Next-state logic for counter and control
  always_comb begin
    // Counter: restart wins, the stopped timer sits at zero
    if (restart || expire || !run) begin
      cnt_d = 20'h00000;
    end else if (tick) begin
      cnt_d = cnt_q + 20'h00001;
    end else begin
      cnt_d = cnt_q;
    end
    // Change window countdown
    if (open_wr) begin
      ce_cnt_d = wdr_pkg::CE_CYCLES;
    end else if (chg_wr) begin
      ce_cnt_d = 3'h0;
    end else if (ce_open) begin
      ce_cnt_d = ce_cnt_q - 3'h1;
    end else begin
      ce_cnt_d = ce_cnt_q;
    end
    // Reset enable may be set at any time but cleared only in a window
    if (chg_wr) begin
      re_d = reg_wdata[wdr_pkg::CTRL_RE];
    end else if (wr_ctrl && reg_wdata[wdr_pkg::CTRL_RE]) begin
      re_d = 1'b1;
    end else begin
      re_d = re_q;
    end
    psel_d = chg_wr ? {reg_wdata[wdr_pkg::CTRL_PS3], reg_wdata[wdr_pkg::CTRL_PS_HI:0]}
                    : psel_q;
    // A software write in the same cycle beats the vector's clear
    if (wr_ctrl) begin
      ie_d = reg_wdata[wdr_pkg::CTRL_IE];
    end else if (vec_clr_ie) begin
      ie_d = 1'b0;
    end else begin
      ie_d = ie_q;
    end
    // Flag: a new time-out beats any clear in the same cycle
    if (set_flag) begin
      flag_d = 1'b1;
    end else if (clr_flag) begin
      flag_d = 1'b0;
    end else begin
      flag_d = flag_q;
    end
  end

  // Reset-cause flags: events win over power-on and software clears
  always_comb begin
    cause_d = cause_q;
    if (poweron_evt) begin
      cause_d[wdr_pkg::CAUSE_WD] = 1'b0;
      cause_d[wdr_pkg::CAUSE_BO] = 1'b0;
      cause_d[wdr_pkg::CAUSE_EXT] = 1'b0;
    end
    if (wr_cause) begin
      cause_d = cause_d & reg_wdata[3:0];
    end
    if (rst_fire) begin
      cause_d[wdr_pkg::CAUSE_WD] = 1'b1;
    end
    if (brownout_evt) begin
      cause_d[wdr_pkg::CAUSE_BO] = 1'b1;
    end
    if (external_evt) begin
      cause_d[wdr_pkg::CAUSE_EXT] = 1'b1;
    end
    if (poweron_evt) begin
      cause_d[wdr_pkg::CAUSE_PO] = 1'b1;
    end
  end

  // Control state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 20'h00000;
      ce_cnt_q <= 3'h0;
      re_q <= wdr_pkg::CTRL_RESET[wdr_pkg::CTRL_RE];
      ie_q <= wdr_pkg::CTRL_RESET[wdr_pkg::CTRL_IE];
      flag_q <= wdr_pkg::CTRL_RESET[wdr_pkg::CTRL_IF];
      psel_q <= 4'h0;
      cause_q <= wdr_pkg::CAUSE_RESET[3:0];
    end else begin
      cnt_q <= cnt_d;
      ce_cnt_q <= ce_cnt_d;
      re_q <= re_d;
      ie_q <= ie_d;
      flag_q <= flag_d;
      psel_q <= psel_d;
      cause_q <= cause_d;
    end
  end

  // Outputs, all registered; the delay start marks the pulse's falling edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdt_reset_pulse <= 1'b0;
      startup_delay_start <= 1'b0;
      wdt_irq <= 1'b0;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      wdt_reset_pulse <= rst_fire;
      startup_delay_start <= wdt_reset_pulse;
      wdt_irq <= irq_d;
      reg_rdata <= reg_rd ? rdata_d : reg_rdata;
      reg_rvalid <= reg_rd;
    end
  end

  // Checks on the block's own behaviour
  sequence s_open_then_quiet;
    open_wr ##1 (!reg_wr) [*4];
  endsequence

  sequence s_combined_expiry;
    expire && re_eff && ie_eff && !flag_q;
  endsequence

  pulse_one_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wdt_reset_pulse |=> !wdt_reset_pulse)
    else $error("watchdog reset pulse longer than one cycle");

  delay_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(wdt_reset_pulse) |-> startup_delay_start)
    else $error("startup delay not started on pulse fall");

  restart_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    restart |=> (cnt_q == 20'h00000))
    else $error("restart did not clear the counter");

  irq_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (expire && ie_eff && !re_eff) |=> (flag_q && !wdt_reset_pulse))
    else $error("interrupt mode expiry mishandled");

  reset_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (expire && re_eff && !ie_eff) |=> wdt_reset_pulse)
    else $error("reset mode expiry gave no reset");

  combined_first_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_combined_expiry |=> (flag_q && !wdt_reset_pulse))
    else $error("combined mode first expiry mishandled");

  fuse_lock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    always_on_fuse |-> (ctrl_view[wdr_pkg::CTRL_RE] && !ctrl_view[wdr_pkg::CTRL_IE]))
    else $error("fuse did not lock the mode bits");

  window_close_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_open_then_quiet |=> !ce_open)
    else $error("change window open too long");

  prescale_lock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_ctrl && !ce_open) |=> $stable(psel_q))
    else $error("prescale changed outside a window");

  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wdt_irq |-> $past(global_int_enable && flag_q))
    else $error("interrupt raised without enable and flag");

  cause_force_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cause_q[wdr_pkg::CAUSE_WD] |-> ctrl_view[wdr_pkg::CTRL_RE])
    else $error("reset enable not forced by watchdog cause");

  cause_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wdt_reset_pulse |-> cause_q[wdr_pkg::CAUSE_WD])
    else $error("watchdog cause not set by watchdog reset");

  vector_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (vector_taken && re_eff && !wr_ctrl && !set_flag) |=> (!ie_q && !flag_q))
    else $error("vector did not clear enable and flag");

  // Power-on leaves only its own cause behind when nothing else fires with it
  cause_poweron_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (poweron_evt && !brownout_evt && !external_evt && !rst_fire) |=> (cause_q == 4'h1))
    else $error("power-on did not leave only its own cause");

  re_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (chg_wr && !reg_wdata[wdr_pkg::CTRL_RE]) |=> !re_q)
    else $error("reset enable not cleared inside a window");

  // Reserved codes must not shorten the period below the longest one
  reserved_clamp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (psel_q > wdr_pkg::PSEL_MAX) |-> (cnt_last == 20'hFFFFF))
    else $error("reserved prescale code not held at the longest period");

endmodule : wdr_top

`default_nettype wire

// ### tb/wdr_core_model.sv
// Core-side model: takes the watchdog vector when the interrupt is requested.
// Assumes it shares clk_sys and rst_n with the block under test.
`timescale 1ns/10ps
`default_nettype none

module wdr_core_model #(
  parameter int SVC_DELAY = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Service control and request
  input wire logic svc_en,
  input wire logic wdt_irq,
  // Vector fetch strobe
  output logic vector_taken
);
  // Vector is taken a few cycles late, as a core finishing an instruction would
  initial begin
    vector_taken = 1'b0;
    forever begin
      @(posedge clk_sys);
      #1;
      if (svc_en && rst_n && wdt_irq === 1'b1) begin
        repeat (SVC_DELAY) @(posedge clk_sys);
        #1;
        vector_taken = 1'b1;
        @(posedge clk_sys);
        #1;
        vector_taken = 1'b0;
        // Let the request fall before looking again
        repeat (2) @(posedge clk_sys);
      end
    end
  end
endmodule : wdr_core_model

`default_nettype wire

// ### tb/test_watchdog_with_reset_flags.sv
// Testbench for the watchdog and reset-cause block, driven through its register port.
// Assumes the oscillator may run at one rise per 8 system clocks.
`timescale 1ns/10ps
`default_nettype none

module test_watchdog_with_reset_flags;
  localparam int OSC_P = 8;
  localparam int T_LO = 2047 * OSC_P;
  localparam int T_HI = 2048 * OSC_P + 6;
  localparam logic [7:0] CA = wdr_pkg::ADDR_CAUSE;
  localparam logic [7:0] CT = wdr_pkg::ADDR_CTRL;
  localparam logic [7:0] IO_CA = CA - wdr_pkg::IO_OFFSET;
  logic clk_sys, rst_n, osc_in, reg_wr, reg_rd, io_space, restart, vector_taken;
  logic global_int_enable, always_on_fuse, poweron_evt, brownout_evt, external_evt;
  logic svc_en, reg_rvalid, wdt_reset_pulse, startup_delay_start, wdt_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int err_total, cmp_count;

  wdr_top u_wdr_top (.clk_sys(clk_sys), .rst_n(rst_n), .osc_in(osc_in), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .io_space(io_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .restart(restart),
    .vector_taken(vector_taken), .global_int_enable(global_int_enable),
    .always_on_fuse(always_on_fuse), .poweron_evt(poweron_evt),
    .brownout_evt(brownout_evt), .external_evt(external_evt),
    .wdt_reset_pulse(wdt_reset_pulse), .startup_delay_start(startup_delay_start),
    .wdt_irq(wdt_irq));

  wdr_core_model u_wdr_core_model (.clk_sys(clk_sys), .rst_n(rst_n), .svc_en(svc_en),
    .wdt_irq(wdt_irq), .vector_taken(vector_taken));

  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Slow oscillator, one rise every OSC_P clocks
  initial begin
    osc_in = 1'b0;
    forever begin
      repeat (OSC_P / 2) @(posedge clk_sys);
      #1;
      osc_in = ~osc_in;
    end
  end

  task automatic final_report;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // Register write, one idle edge after it so strobes never toggle twice at once
  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    io_space = io;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : wr

  task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] exp,
                    input logic [7:0] m = 8'hFF);
    io_space = io;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("rdata", exp, reg_rdata & m);
    @(posedge clk_sys);
    #1;
  endtask : rd

  // One-cycle pulse on {restart, poweron, brownout, external}
  task automatic pulse(input logic [3:0] v);
    {restart, poweron_evt, brownout_evt, external_evt} = v;
    @(posedge clk_sys);
    #1;
    {restart, poweron_evt, brownout_evt, external_evt} = 4'h0;
    @(posedge clk_sys);
    #1;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  // Bounded wait for the irq or the reset pulse; the other one must stay quiet
  task automatic wait_sig(input logic is_rst, input int lo, input int hi);
    int n;
    logic other;
    n = 0;
    other = 1'b0;
    while ((is_rst ? wdt_reset_pulse : wdt_irq) !== 1'b1 && n <= hi) begin
      @(posedge clk_sys);
      #1;
      n++;
      other = other | ((is_rst ? wdt_irq : wdt_reset_pulse) === 1'b1);
    end
    chk("delay", 8'h01, {7'h00, n >= lo && n <= hi});
    chk("other", 8'h00, {7'h00, other});
    if (n > hi) final_report();
    if (is_rst) begin
      chk("start", 8'h00, {7'h00, startup_delay_start});
      @(posedge clk_sys);
      #1;
      chk("pulse", 8'h01, {3'h0, wdt_reset_pulse, 3'h0, startup_delay_start});
      @(posedge clk_sys);
      #1;
      chk("start", 8'h00, {7'h00, startup_delay_start});
    end
  endtask : wait_sig

  initial begin
    {rst_n, reg_wr, reg_rd, io_space, restart, global_int_enable, svc_en} = 7'h00;
    {always_on_fuse, poweron_evt, brownout_evt, external_evt} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    err_total = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    // Map, reset values, unmapped place
    rd(1'b0, CA, wdr_pkg::CAUSE_RESET);
    rd(1'b1, IO_CA, wdr_pkg::CAUSE_RESET);
    rd(1'b0, CT, wdr_pkg::CTRL_RESET);
    wr(1'b0, 8'h61, 8'hFF);
    rd(1'b0, 8'h61, 8'h00);
    rd(1'b0, CT, 8'h00);
    // Reset-cause flags
    pulse(4'h4);
    rd(1'b1, IO_CA, 8'h01);
    pulse(4'h2);
    pulse(4'h1);
    rd(1'b1, IO_CA, 8'h07);
    wr(1'b1, IO_CA, 8'h0E);
    rd(1'b0, CA, 8'h06);
    pulse(4'h4);
    rd(1'b0, CA, 8'h01);
    wr(1'b0, CA, 8'h00);
    rd(1'b0, CA, 8'h00);
    // Protected change of reset enable and prescale
    wr(1'b0, CT, 8'h08);
    rd(1'b0, CT, 8'h08);
    wr(1'b0, CT, 8'h01);
    rd(1'b0, CT, 8'h08);
    wr(1'b0, CT, 8'h18);
    idle(2);
    wr(1'b0, CT, 8'h01);
    rd(1'b0, CT, 8'h01);
    wr(1'b0, CT, 8'h18);
    rd(1'b0, CT, 8'h19);
    idle(1);
    wr(1'b0, CT, 8'h00);
    rd(1'b0, CT, 8'h09);
    wr(1'b0, CT, 8'h18);
    wr(1'b0, CT, 8'h00);
    rd(1'b0, CT, 8'h00);
    // A reserved prescale code is kept as written, then put back
    wr(1'b0, CT, 8'h18);
    wr(1'b0, CT, 8'h27);
    rd(1'b0, CT, 8'h27);
    wr(1'b0, CT, 8'h18);
    wr(1'b0, CT, 8'h00);
    rd(1'b0, CT, 8'h00);
    // Interrupt mode, with an early restart
    wr(1'b0, CT, 8'h40);
    global_int_enable = 1'b1;
    pulse(4'h8);
    idle(500 * OSC_P);
    pulse(4'h8);
    wait_sig(1'b0, T_LO, T_HI);
    global_int_enable = 1'b0;
    idle(2);
    chk("irq", 8'h00, {7'h00, wdt_irq});
    rd(1'b0, CT, 8'hC0);
    wr(1'b0, CT, 8'hC0);
    rd(1'b0, CT, 8'h40);
    rd(1'b0, CA, 8'h00);
    // Combined mode: interrupt, vector taken, then reset
    wr(1'b0, CT, 8'h48);
    svc_en = 1'b1;
    global_int_enable = 1'b1;
    pulse(4'h8);
    wait_sig(1'b0, T_LO, T_HI);
    idle(12);
    wait_sig(1'b1, T_LO - 3 * OSC_P, T_HI);
    rd(1'b0, CT, 8'h08);
    rd(1'b0, CA, 8'h08);
    wr(1'b0, CT, 8'h18);
    wr(1'b0, CT, 8'h00);
    rd(1'b0, CT, 8'h08);
    pulse(4'h4);
    rd(1'b0, CA, 8'h01);
    wr(1'b0, CA, 8'h00);
    rd(1'b0, CT, 8'h00);
    // Fuse forces reset mode
    always_on_fuse = 1'b1;
    svc_en = 1'b0;
    wr(1'b0, CT, 8'h40);
    rd(1'b0, CT, 8'h08, 8'h48);
    pulse(4'h8);
    wait_sig(1'b1, T_LO, T_HI);
    rd(1'b0, CA, 8'h08);
    final_report();
  end
endmodule : test_watchdog_with_reset_flags

`default_nettype wire
